// ===== design/vct_regs.sv
// What this block does
// - Pending-base write visible once propagation flag clears
// - Bit 63 marks table valid, resets 0
// - Bits 61:59 read-only entry doublewords minus one
// - Bits 58:56 outer cacheability, 000 uses inner
// - Attributes programmable by default, hard-wired optional
// - Bit 55 picks flat or two-level table
// - Two-level descriptors read as 64-bit little-endian
// - Flat-only build: indirection reads zero, ignores writes
// - Page size 4K/16K/64K, code 11 means 64K
// - Valid rising uses known-zero hint
// - Hint written zero with bit 63 set forces configuration refetch
// - Known-zero hint always reads back zero
// - Bits 51:12 base address, above width zero
// - Shareability in 11:10, code 11 acts 00
// - Inner cacheability in 9:7, 000 device memory
// - Bits 6:0 page count minus one
// - Older layout: 63:59, 55:52 reserved
// - Older layout: 4:0 identifier width minus one
// - Identifier width below 14 (field below 13): all out of range
//
// Register block for the virtual configuration table base and the tail
// of the virtual pending table base. Assumes one 64-bit access per
// request, taken on the clock edge, answered one cycle later.
`timescale 1ns/1ps
`include "vct_defines.svh"

module vct_regs #(
   parameter bit NEW_LAYOUT = 1'b1,
   parameter int PA_WIDTH = 52,
   parameter bit FLAT_ONLY = 1'b0,
   parameter bit ATTR_PROG = 1'b1,
   parameter logic [2:0] FIXED_OUTER = 3'h0,
   parameter logic [2:0] FIXED_INNER = 3'h1,
   parameter logic [1:0] FIXED_SHARE = 2'h0,
   parameter bit PSIZE_FIXED = 1'b0,
   parameter logic [1:0] FIXED_PSIZE = 2'h0,
   parameter logic [2:0] ENTRY_SIZE_M1 = 3'h1,
   parameter int PROP_CYCLES =
      (`VCT_PROP_TIME_NS + `VCT_CLK_PERIOD_NS - 1) / `VCT_CLK_PERIOD_NS
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire vct_pkg::vct_req_s i_req,
   output logic [63:0] o_rdata,
   output logic o_ack,
   output vct_pkg::vct_cfg_s o_cfg,
   output logic o_cfg_reload,
   output logic o_cfg_zero_init,
   input wire logic i_desc_valid,
   input wire logic [63:0] i_desc_data,
   output logic o_desc_valid,
   output logic [39:0] o_desc_page_addr,
   output logic o_write_propagation_pending
);

   ////////////////////////////////////////////////////////////////////
   // Helpers

   // Clears address bits above the implemented physical width
   function automatic logic [39:0] pa_mask(input logic [39:0] a);
      logic [39:0] m;
      m = '0;
      for (int i = 0; i < 40; i++) begin
         m[i] = ((i + 12) < PA_WIDTH) ? a[i] : 1'b0;
      end
      return m;
   endfunction : pa_mask

   // Mask over a 64-bit pending-base write value
   function automatic logic [63:0] pend_mask(input logic [63:0] w);
      logic [63:0] m;
      m = w & `VCT_PEND_WMASK;
      m[`VCT_CFG_PA_HI:`VCT_CFG_PA_LO] = pa_mask(m[`VCT_CFG_PA_HI:`VCT_CFG_PA_LO]);
      return m;
   endfunction : pend_mask

   vct_pkg::vct_state_s st_r;
   vct_pkg::vct_state_s st_nxt;
   logic wr_cfg;
   logic wr_pend;
   logic rd_cfg;
   logic rd_pend;
   logic [63:0] cfg_view;
   logic [63:0] wd;
   logic z_hint;
   logic going_valid;

   ////////////////////////////////////////////////////////////////////
   // Address decode of the two registers
   assign wd = i_req.wdata;
   assign wr_cfg = i_req.wr && (i_req.addr == `VCT_OFF_CFG_BASE);
   assign wr_pend = i_req.wr && (i_req.addr == `VCT_OFF_PEND_BASE);
   assign rd_cfg = i_req.rd && (i_req.addr == `VCT_OFF_CFG_BASE);
   assign rd_pend = i_req.rd && (i_req.addr == `VCT_OFF_PEND_BASE);
   assign z_hint = NEW_LAYOUT && wd[`VCT_CFG_ZERO];
   assign going_valid = NEW_LAYOUT && wr_cfg && !st_r.cfg_valid && wd[`VCT_CFG_VALID];

   ////////////////////////////////////////////////////////////////////
   // Software view of the configuration base register
   always_comb begin
      cfg_view = '0; // Reserved bits and the hint read as zero
      cfg_view[`VCT_CFG_OUTER_HI:`VCT_CFG_OUTER_LO] = st_r.outer;
      cfg_view[`VCT_CFG_PA_HI:`VCT_CFG_PA_LO] = st_r.pa;
      cfg_view[`VCT_CFG_SHARE_HI:`VCT_CFG_SHARE_LO] = st_r.share;
      cfg_view[`VCT_CFG_INNER_HI:`VCT_CFG_INNER_LO] = st_r.inner;
      if (NEW_LAYOUT) begin
         cfg_view[`VCT_CFG_VALID] = st_r.cfg_valid;
         cfg_view[`VCT_CFG_ESIZE_HI:`VCT_CFG_ESIZE_LO] = ENTRY_SIZE_M1;
         cfg_view[`VCT_CFG_INDIRECT] = st_r.indirect;
         cfg_view[`VCT_CFG_PSIZE_HI:`VCT_CFG_PSIZE_LO] = st_r.psize;
         cfg_view[`VCT_CFG_SIZE_HI:`VCT_CFG_SIZE_LO] = st_r.size;
      end else begin
         // Older layout keeps only the identifier width low bits
         cfg_view[`VCT_CFG_IDW_HI:`VCT_CFG_IDW_LO] = st_r.size[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Next-state logic of every register in the block except the propagation tracker
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = i_req.rd || i_req.wr;
      st_nxt.reload = 1'b0;
      st_nxt.zero_init = 1'b0;
      st_nxt.desc_v = 1'b0;

      // Configuration base write
      if (wr_cfg) begin
         if (NEW_LAYOUT) begin
            st_nxt.cfg_valid = wd[`VCT_CFG_VALID];
            if (!FLAT_ONLY) begin
               st_nxt.indirect = wd[`VCT_CFG_INDIRECT];
            end
            if (!PSIZE_FIXED) begin
               st_nxt.psize = wd[`VCT_CFG_PSIZE_HI:`VCT_CFG_PSIZE_LO];
            end
            st_nxt.size = wd[`VCT_CFG_SIZE_HI:`VCT_CFG_SIZE_LO];
         end else begin
            st_nxt.size = {2'h0, wd[`VCT_CFG_IDW_HI:`VCT_CFG_IDW_LO]};
         end
         // Attributes are stored only when programmable
         if (ATTR_PROG) begin
            st_nxt.outer = wd[`VCT_CFG_OUTER_HI:`VCT_CFG_OUTER_LO];
            st_nxt.share = wd[`VCT_CFG_SHARE_HI:`VCT_CFG_SHARE_LO];
            st_nxt.inner = wd[`VCT_CFG_INNER_HI:`VCT_CFG_INNER_LO];
         end
         st_nxt.pa = pa_mask(wd[`VCT_CFG_PA_HI:`VCT_CFG_PA_LO]);
      end

      // Hint is sampled at write time only, never stored
      if (going_valid) begin
         // Zeroed table needs no fetch; software vouches for it
         st_nxt.zero_init = z_hint;
         st_nxt.reload = !z_hint;
      end else if (NEW_LAYOUT && wr_cfg && wd[`VCT_CFG_VALID] && !z_hint) begin
         st_nxt.reload = 1'b1; // Hint left at zero refetches
      end

      // Pending base write, reserved and status bits dropped
      if (wr_pend) begin
         st_nxt.pend = pend_mask(wd);
      end

      // Read data, zero for any unmapped offset
      if (rd_cfg) begin
         st_nxt.rdata = cfg_view;
      end else if (rd_pend) begin
         st_nxt.rdata = st_r.pend;
      end else if (i_req.rd) begin
         st_nxt.rdata = '0;
      end

      // First-level descriptor: lane k holds the byte at offset k, so the
      // word is already little-endian ordered
      if (i_desc_valid && st_r.cfg_valid && st_r.indirect) begin
         st_nxt.desc_v = 1'b1;
         st_nxt.desc_pa = pa_mask(i_desc_data[`VCT_CFG_PA_HI:`VCT_CFG_PA_LO]);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register; fields with no defined reset still start at zero
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_r <= '0; // Valid bits clear at reset
         st_r.outer <= ATTR_PROG ? 3'h0 : FIXED_OUTER;
         st_r.share <= ATTR_PROG ? 2'h0 : FIXED_SHARE;
         st_r.inner <= ATTR_PROG ? 3'h0 : FIXED_INNER;
         st_r.psize <= PSIZE_FIXED ? FIXED_PSIZE : 2'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Propagation of pending-base writes through the hierarchy
   vct_prop_tracker #(
      .CYCLES(PROP_CYCLES)
   ) u_prop (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_write(wr_pend),
      .o_pending(o_write_propagation_pending)
   );

   ////////////////////////////////////////////////////////////////////
   // Effective attributes seen by the table walker
   always_comb begin
      o_cfg = '0;
      o_cfg.valid = NEW_LAYOUT && st_r.cfg_valid;
      o_cfg.entry_size_m1 = NEW_LAYOUT ? ENTRY_SIZE_M1 : 3'h0;
      // Outer code zero means follow the inner setting
      o_cfg.outer_cacheability_attr = st_r.outer;
      o_cfg.indirect = NEW_LAYOUT && st_r.indirect;
      // Reserved page code behaves as the largest page
      o_cfg.page_size = (st_r.psize == 2'h3) ? `VCT_PSIZE_64K : st_r.psize;
      o_cfg.base_addr = st_r.pa;
      // Reserved shareability acts as non-shareable
      o_cfg.shareability = (st_r.share == `VCT_SHARE_RSVD) ? `VCT_SHARE_NON : st_r.share;
      o_cfg.inner_cacheability_attr = st_r.inner;
      o_cfg.page_count_m1 = NEW_LAYOUT ? st_r.size : 7'h0;
      o_cfg.identifier_width_minus_one = NEW_LAYOUT ? 5'h0 : st_r.size[4:0];
      // Too narrow an identifier leaves every message out of range
      o_cfg.msg_out_of_range = !NEW_LAYOUT && (st_r.size[4:0] < `VCT_IDW_MIN);
   end

   assign o_rdata = st_r.rdata;
   assign o_ack = st_r.ack;
   assign o_cfg_reload = st_r.reload;
   assign o_cfg_zero_init = st_r.zero_init;
   assign o_desc_valid = st_r.desc_v;
   assign o_desc_page_addr = st_r.desc_pa;

endmodule : vct_regs

// ===== common/vct_defines.svh
// Offsets, field positions, reset values and timing counts of the
// virtual configuration table base register block.
// Assumes a single 64-bit register access port, 16-bit byte offsets.
`ifndef VCT_DEFINES_SVH
`define VCT_DEFINES_SVH

// Register offsets inside the virtual message frame
`define VCT_OFF_CFG_BASE 16'h0070
`define VCT_OFF_PEND_BASE 16'h0078

// Configuration table base, newer layout
`define VCT_CFG_VALID 63
`define VCT_CFG_ESIZE_HI 61
`define VCT_CFG_ESIZE_LO 59
`define VCT_CFG_OUTER_HI 58
`define VCT_CFG_OUTER_LO 56
`define VCT_CFG_INDIRECT 55
`define VCT_CFG_PSIZE_HI 54
`define VCT_CFG_PSIZE_LO 53
`define VCT_CFG_ZERO 52
`define VCT_CFG_PA_HI 51
`define VCT_CFG_PA_LO 12
`define VCT_CFG_SHARE_HI 11
`define VCT_CFG_SHARE_LO 10
`define VCT_CFG_INNER_HI 9
`define VCT_CFG_INNER_LO 7
`define VCT_CFG_SIZE_HI 6
`define VCT_CFG_SIZE_LO 0
// Older layout identifier width field
`define VCT_CFG_IDW_HI 4
`define VCT_CFG_IDW_LO 0
// Identifier width minus one fields below this give no usable message interrupts
`define VCT_IDW_MIN 5'h0D

// Pending table base writable bits: valid, area invalid, outer,
// address 51:16, shareability, inner cacheability
`define VCT_PEND_WMASK 64'hC70F_FFFF_FFFF_0F80
`define VCT_PEND_VALID 63

// Encodings
`define VCT_PSIZE_64K 2'h2
`define VCT_SHARE_RSVD 2'h3
`define VCT_SHARE_NON 2'h0

// Reset values
`define VCT_RESET_VAL 64'h0000_0000_0000_0000

// Propagation time of a pending-base write through the hierarchy
`define VCT_PROP_TIME_NS 200
`define VCT_CLK_PERIOD_NS 20

`endif

// ===== common/vct_pkg.sv
// Types shared by the virtual configuration table base register block.
// Assumes vct_defines.svh supplies the numeric constants.
package vct_pkg;

   // Register access request from the redistributor frame decoder
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [63:0] wdata;
   } vct_req_s;

   // Decoded table attributes handed to the table-walk logic
   typedef struct packed {
      logic valid;
      logic [2:0] entry_size_m1;
      logic [2:0] outer_cacheability_attr;
      logic indirect;
      logic [1:0] page_size;
      logic [39:0] base_addr;
      logic [1:0] shareability;
      logic [2:0] inner_cacheability_attr;
      logic [6:0] page_count_m1;
      logic [4:0] identifier_width_minus_one;
      logic msg_out_of_range;
   } vct_cfg_s;

   // Whole register state of the block, apart from the propagation tracker
   typedef struct packed {
      logic cfg_valid;
      logic [2:0] outer;
      logic indirect;
      logic [1:0] psize;
      logic [39:0] pa;
      logic [1:0] share;
      logic [2:0] inner;
      logic [6:0] size;
      logic [63:0] pend;
      logic [63:0] rdata;
      logic ack;
      logic reload;
      logic zero_init;
      logic desc_v;
      logic [39:0] desc_pa;
   } vct_state_s;

endpackage : vct_pkg

// ===== design/vct_prop_tracker.sv
// Write propagation tracker: holds a pending flag for a fixed time
// after each pending-base write. Assumes synchronous active-high reset.
`timescale 1ns/1ps
`include "vct_defines.svh"

module vct_prop_tracker #(
   parameter int CYCLES = 10
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_write,
   output logic o_pending
);

   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic pend;
   } vct_trk_s;

   vct_trk_s st_r;
   vct_trk_s st_nxt;

   ////////////////////////////////////////////////////////////////////
   // Each write restarts the wait, so the flag covers the last write
   always_comb begin
      st_nxt = st_r;
      if (i_write) begin
         st_nxt.cnt = CW'(CYCLES);
         st_nxt.pend = 1'b1;
      end else if (st_r.cnt > CW'(1)) begin
         st_nxt.cnt = st_r.cnt - CW'(1);
      end else begin
         st_nxt.cnt = '0;
         st_nxt.pend = 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_pending = st_r.pend;

endmodule : vct_prop_tracker

// ===== tb/vct_regs_assertions.sv
// Port-level checks of the table base register block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "vct_defines.svh"
module vct_regs_assertions #(
   parameter bit NEW_LAYOUT = 1'b1,
   parameter logic [2:0] ENTRY_SIZE_M1 = 3'h1,
   parameter int PROP_CYCLES = 10
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire vct_pkg::vct_req_s i_req,
   input wire logic [63:0] o_rdata,
   input wire logic o_ack,
   input wire vct_pkg::vct_cfg_s o_cfg,
   input wire logic o_cfg_reload,
   input wire logic o_cfg_zero_init,
   input wire logic i_desc_valid,
   input wire logic [63:0] i_desc_data,
   input wire logic o_desc_valid,
   input wire logic [39:0] o_desc_page_addr,
   input wire logic o_write_propagation_pending
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   logic [7:0] since_r;
   logic [7:0] since_nxt;
   wire cfg_wr = i_req.wr && i_req.addr == `VCT_OFF_CFG_BASE;
   wire take = i_desc_valid && o_cfg.valid && o_cfg.indirect;
   ////////////////////////////////////////////////////////////////////
   // Cycles since the last pending-base write; saturates so it never wraps
   always_comb begin
      since_nxt = since_r;
      if (i_rst)
         since_nxt = 8'h00;
      else if (i_req.wr && i_req.addr == `VCT_OFF_PEND_BASE)
         since_nxt = 8'h01;
      else if (since_r != 8'h00 && since_r != 8'hFF)
         since_nxt = since_r + 8'h01;
   end
   always_ff @(posedge i_mclk) begin
      since_r <= since_nxt;
   end
   ////////////////////////////////////////////////////////////////////
   // Valid-setting writes, split by the known-zero hint
   sequence s_rise_zero;
      NEW_LAYOUT && cfg_wr && i_req.wdata[63] && i_req.wdata[52] && !o_cfg.valid;
   endsequence
   sequence s_live_write;
      NEW_LAYOUT && cfg_wr && i_req.wdata[63] && !i_req.wdata[52];
   endsequence
   ack_follows_a: assert property (o_ack == $past(i_req.rd || i_req.wr))
      else $error("ack not one cycle after access");
   hint_reads_zero_a: assert property (
      o_ack && $past(i_req.rd && i_req.addr == `VCT_OFF_CFG_BASE)
      |-> o_rdata[52] == 1'b0 && o_rdata[62] == 1'b0)
      else $error("hint or reserved bit read nonzero");
   entry_size_ro_a: assert property (NEW_LAYOUT |-> o_cfg.entry_size_m1 == ENTRY_SIZE_M1)
      else $error("entry size changed");
   page_rsvd_a: assert property (o_cfg.page_size != 2'h3)
      else $error("reserved page code not folded");
   share_rsvd_a: assert property (o_cfg.shareability != 2'h3)
      else $error("reserved share code not folded");
   prop_window_a: assert property (
      o_write_propagation_pending == (since_r != 8'h00 && since_r <= PROP_CYCLES))
      else $error("propagation flag window wrong");
   zero_init_a: assert property (s_rise_zero |=> o_cfg_zero_init && !o_cfg_reload)
      else $error("zero init pulse missing");
   reload_a: assert property (s_live_write |=> o_cfg_reload && !o_cfg_zero_init)
      else $error("reload pulse missing");
   cfg_valid_a: assert property (
      NEW_LAYOUT && cfg_wr |=> o_cfg.valid == $past(i_req.wdata[63]))
      else $error("valid bit not written");
   desc_gate_a: assert property (o_desc_valid == $past(take))
      else $error("descriptor gating wrong");
   desc_addr_a: assert property (take |=> o_desc_page_addr == $past(i_desc_data[51:12]))
      else $error("descriptor address wrong");
endmodule : vct_regs_assertions
bind vct_regs vct_regs_assertions #(.NEW_LAYOUT(NEW_LAYOUT), .ENTRY_SIZE_M1(ENTRY_SIZE_M1),
   .PROP_CYCLES(PROP_CYCLES)) vct_regs_assertions_inst (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_req(i_req), .o_rdata(o_rdata), .o_ack(o_ack), .o_cfg(o_cfg),
   .o_cfg_reload(o_cfg_reload), .o_cfg_zero_init(o_cfg_zero_init),
   .i_desc_valid(i_desc_valid), .i_desc_data(i_desc_data), .o_desc_valid(o_desc_valid),
   .o_desc_page_addr(o_desc_page_addr),
   .o_write_propagation_pending(o_write_propagation_pending));

// ===== tb/vct_regs_tb_top.sv
// Self-checking bench: both register layouts side by side on one bus.
// Assumes every access is answered one cycle after it is taken.
`timescale 1ns/1ps
`include "vct_defines.svh"
module vct_regs_tb_top;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   vct_pkg::vct_req_s req = '0;
   logic dv = 1'b0;
   logic [63:0] dd = '0;
   logic [63:0] rd_n, rd_o;
   logic ack, rel, zin, odv, pend;
   logic [39:0] dpa;
   vct_pkg::vct_cfg_s cfg, cfg_o;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;
   logic [31:0] seed = 32'd63929;
   logic vm = 1'b0;
   ////////////////////////////////////////////////////////////////////
   vct_regs #(.PROP_CYCLES(2)) vct_regs_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(req),
      .o_rdata(rd_n), .o_ack(ack), .o_cfg(cfg), .o_cfg_reload(rel), .o_cfg_zero_init(zin),
      .i_desc_valid(dv), .i_desc_data(dd), .o_desc_valid(odv), .o_desc_page_addr(dpa),
      .o_write_propagation_pending(pend));
   // Older layout twin; only its read view and decode are compared
   vct_regs #(.NEW_LAYOUT(1'b0), .PROP_CYCLES(2)) vct_regs_old_inst (.i_mclk(i_mclk),
      .i_rst(i_rst), .i_req(req), .o_rdata(rd_o), .o_ack(), .o_cfg(cfg_o),
      .o_cfg_reload(), .o_cfg_zero_init(), .i_desc_valid(dv), .i_desc_data(dd),
      .o_desc_valid(), .o_desc_page_addr(), .o_write_propagation_pending());
   // Clock and hang guard
   always #10 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk
   // One access; returns just after the answer edge
   task automatic acc(input logic r, input logic w, input logic [15:0] a, input logic [63:0] d);
      @(posedge i_mclk);
      #1 req = '{rd: r, wr: w, addr: a, wdata: d};
      @(posedge i_mclk);
      #1 req = '0;
      chk("ack", 64'h1, {63'h0, ack});
   endtask : acc
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////
   initial begin
      logic [63:0] w;
      repeat (20) @(posedge i_mclk);
      #1 i_rst = 1'b0;
      acc(1'b1, 1'b0, `VCT_OFF_CFG_BASE, '0);
      chk("cfg_rst", 64'h0800_0000_0000_0000, rd_n);
      acc(1'b1, 1'b0, `VCT_OFF_PEND_BASE, '0);
      chk("pend_rst", 64'h0, rd_n);
      $display("test reset done");
      // Random configuration writes against the bench model
      for (int i = 0; i < 40; i++) begin
         w = {rnd(), rnd()};
         if (vm || !w[63]) w[52] = 1'b0; // Hint only on a rise over zeroed memory
         if (i < 2) w[4:0] = (i == 0) ? 5'h0C : 5'h0D;
         acc(1'b0, 1'b1, `VCT_OFF_CFG_BASE, w);
         chk("zero_init", {63'h0, w[63] && !vm && w[52]}, {63'h0, zin});
         chk("reload", {63'h0, w[63] && !w[52]}, {63'h0, rel});
         vm = w[63];
         chk("page", {62'h0, (w[54:53] == 2'h3) ? 2'h2 : w[54:53]}, {62'h0, cfg.page_size});
         chk("share", {62'h0, (w[11:10] == 2'h3) ? 2'h0 : w[11:10]}, {62'h0, cfg.shareability});
         chk("fields", {9'h0, w[63], w[55], w[51:12], w[9:7], w[6:0], w[58:56]},
            {9'h0, cfg.valid, cfg.indirect, cfg.base_addr, cfg.inner_cacheability_attr,
            cfg.page_count_m1, cfg.outer_cacheability_attr});
         chk("idw", {59'h0, w[4:0]}, {59'h0, cfg_o.identifier_width_minus_one});
         chk("oor", {63'h0, w[4:0] < 5'h0D}, {63'h0, cfg_o.msg_out_of_range});
         acc(1'b1, 1'b0, `VCT_OFF_CFG_BASE, '0);
         chk("cfg_new", (w & 64'h87EF_FFFF_FFFF_FFFF) | 64'h0800_0000_0000_0000, rd_n);
         chk("cfg_old", w & 64'h070F_FFFF_FFFF_FF9F, rd_o);
      end
      $display("test config done");
      // Pending base: propagation window, read view, unmapped place
      w = {rnd(), rnd()};
      acc(1'b0, 1'b1, `VCT_OFF_PEND_BASE, w);
      chk("prop1", 64'h1, {63'h0, pend});
      @(posedge i_mclk);
      #1 chk("prop2", 64'h1, {63'h0, pend});
      @(posedge i_mclk);
      #1 chk("prop3", 64'h0, {63'h0, pend});
      acc(1'b1, 1'b0, `VCT_OFF_PEND_BASE, '0);
      chk("pend", w & 64'hC70F_FFFF_FFFF_0F80, rd_n);
      acc(1'b1, 1'b1, 16'h0080, w);
      chk("unmapped", 64'h0, rd_n);
      $display("test pending done");
      // Descriptors: taken when two-level, dropped when flat
      acc(1'b0, 1'b1, `VCT_OFF_CFG_BASE, 64'h8080_0000_0000_0000);
      for (int k = 0; k < 2; k++) begin
         w = {rnd(), rnd()};
         @(posedge i_mclk);
         #1 dv = 1'b1;
         dd = w;
         @(posedge i_mclk);
         #1 dv = 1'b0;
         chk("desc_v", {63'h0, k == 0}, {63'h0, odv});
         if (k == 0) chk("desc_pa", {24'h0, w[51:12]}, {24'h0, dpa});
         acc(1'b0, 1'b1, `VCT_OFF_CFG_BASE, 64'h8000_0000_0000_0000);
      end
      $display("test descriptor done");
      tally_and_finish();
   end
endmodule : vct_regs_tb_top
